// [led_a_regs_pkg.sv]
package led_a_regs_pkg;

  // Bus geometry: byte address, 32-bit data, one byte lane in use
  localparam int ADR_W = 10;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_LEVEL_RAMP = 8'h47;
  localparam logic [7:0] IDX_PHASE1 = 8'h48;
  localparam logic [7:0] IDX_PHASE2 = 8'h49;
  localparam logic [7:0] IDX_PHASE3 = 8'h4a;
  localparam logic [7:0] IDX_PHASE4 = 8'h4b;
  localparam logic [7:0] IDX_DUTY = 8'h4d;
  localparam logic [7:0] IDX_STATUS = 8'h7f;

  // Field positions in the level/ramp register; phase length and duty widths
  localparam int RAMP_BIT = 5;
  localparam int LEVEL_LSB = 0;
  localparam int LEVEL_W = 4;
  localparam int LEN_W = 7;
  localparam int DUTY_W = 5;

  // Reset values, and the full duty code
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 4'h0;
  localparam logic [LEN_W-1:0] LEN_RST = 7'h00;
  localparam logic [DUTY_W-1:0] DUTY_RST = 5'h00;
  localparam logic [DUTY_W-1:0] DUTY_FULL = 5'h1f;

  // Timing: clock rate and documented times in their own units
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned PHASE_UNIT_MS = 64;
  localparam int unsigned PWM_PERIOD_US = 8000;
  localparam int unsigned PWM_SLOTS = 32;
  localparam int unsigned TICK64_CYC = PHASE_UNIT_MS * CLK_KHZ;
  localparam int unsigned SLOT_CYC =
    (PWM_PERIOD_US / PWM_SLOTS) * (CLK_KHZ / 1000);

  // Level and ramp fields carried together
  typedef struct packed {
    logic ramp_on;
    logic [LEVEL_W-1:0] sink_level;
  } level_ctrl_t;

  // Pattern phases, one-hot
  typedef enum logic [3:0] {
    PH1 = 4'b0001,
    PH2 = 4'b0010,
    PH3 = 4'b0100,
    PH4 = 4'b1000
  } phase_t;

endpackage : led_a_regs_pkg

// [led_a_pattern_timing_regs.sv]
// Overview of operation
// - Reserved bits read zero, ignore writes
// - Bit 5 enables ramping when set
// - Low four bits hold sink current code
// - Phase one lasts code times 64 ms
// - Phase two lasts code times 64 ms
// - Phase three lasts code times 64 ms
// - Phase four lasts code times 64 ms
// - Power-on reset clears every writable register
// - Drive output duty (code+1)/32 of 8 ms
module led_a_pattern_timing_regs
  import led_a_regs_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK64_CYC,
  parameter int unsigned PWM_SLOT_CYC = SLOT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [SEL_W-1:0] sel_i,
  input wire logic [DAT_W-1:0] dat_i,
  output logic [DAT_W-1:0] dat_o,
  output logic ack_o,
  output logic [LEVEL_W-1:0] chan_a_sink_level_o,
  output logic chan_a_ramp_on_o,
  output logic [3:0] phase_o,
  output logic chan_a_drive_out_o
);

  // Stored register contents
  level_ctrl_t ctrl_q; // Level code and ramp enable
  logic [LEN_W-1:0] len1_q; // Phase one length in 64 ms units
  logic [LEN_W-1:0] len2_q; // Phase two length
  logic [LEN_W-1:0] len3_q; // Phase three length
  logic [LEN_W-1:0] len4_q; // Phase four length
  logic [DUTY_W-1:0] duty_q; // Drive duty code

  // Bus handshake state
  logic ack_q; // Registered acknowledge
  logic [DAT_W-1:0] rdata_q; // Registered read data
  logic req; // Live request, not yet answered
  logic wr_en; // Write strobe for the low byte lane

  // Sequencer state
  phase_t phase_q; // Current pattern phase
  logic [LEN_W-1:0] cnt_q; // Ticks left in the current phase
  logic [31:0] pre_q; // Prescaler toward one 64 ms tick

  // Drive waveform state
  logic [31:0] slot_pre_q; // Prescaler toward one 250 us slot
  logic [DUTY_W-1:0] slot_q; // Slot index within the 8 ms period
  logic drive_q; // Registered drive output

  // True when the byte address selects the given register index
  function automatic logic hit(input logic [ADR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a[ADR_W-1:2] == idx);
  endfunction : hit

  // Length programmed for a phase
  function automatic logic [LEN_W-1:0] phase_len(input phase_t p);
    unique case (p)
      PH1: phase_len = len1_q;
      PH2: phase_len = len2_q;
      PH3: phase_len = len3_q;
      PH4: phase_len = len4_q;
      default: phase_len = len1_q;
    endcase
  endfunction : phase_len

  // Phase that follows the given one; illegal codes restart at one
  function automatic phase_t next_phase(input phase_t p);
    unique case (p)
      PH1: next_phase = PH2;
      PH2: next_phase = PH3;
      PH3: next_phase = PH4;
      PH4: next_phase = PH1;
      default: next_phase = PH1;
    endcase
  endfunction : next_phase

  // A request is live until it has been acknowledged once
  assign req = cyc_i & stb_i & ~ack_q;
  // Only lane 0 carries data; other lanes are ignored
  assign wr_en = req & we_i & sel_i[0];

  // Acknowledge one cycle after the request, drop it the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // Level and ramp register; reserved bits are simply not stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q.ramp_on <= 1'b0;
      ctrl_q.sink_level <= LEVEL_RST;
    end else if (wr_en && hit(adr_i, IDX_LEVEL_RAMP)) begin
      ctrl_q.ramp_on <= dat_i[RAMP_BIT];
      ctrl_q.sink_level <= dat_i[LEVEL_LSB +: LEVEL_W];
    end
  end

  // Phase length registers; bit 7 is reserved and dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      len1_q <= LEN_RST;
      len2_q <= LEN_RST;
      len3_q <= LEN_RST;
      len4_q <= LEN_RST;
    end else if (wr_en) begin
      // Write only the addressed register
      if (hit(adr_i, IDX_PHASE1)) begin
        len1_q <= dat_i[LEN_W-1:0];
      end
      if (hit(adr_i, IDX_PHASE2)) begin
        len2_q <= dat_i[LEN_W-1:0];
      end
      if (hit(adr_i, IDX_PHASE3)) begin
        len3_q <= dat_i[LEN_W-1:0];
      end
      if (hit(adr_i, IDX_PHASE4)) begin
        len4_q <= dat_i[LEN_W-1:0];
      end
    end
  end

  // Duty code register; bits above the code are reserved
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      duty_q <= DUTY_RST;
    end else if (wr_en && hit(adr_i, IDX_DUTY)) begin
      duty_q <= dat_i[DUTY_W-1:0];
    end
  end

  // Read data, captured with the acknowledge; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else if (req && !we_i) begin
      rdata_q <= '0;
      if (hit(adr_i, IDX_LEVEL_RAMP)) begin
        rdata_q[RAMP_BIT] <= ctrl_q.ramp_on;
        rdata_q[LEVEL_LSB +: LEVEL_W] <= ctrl_q.sink_level;
      end
      if (hit(adr_i, IDX_PHASE1)) begin
        rdata_q[LEN_W-1:0] <= len1_q;
      end
      if (hit(adr_i, IDX_PHASE2)) begin
        rdata_q[LEN_W-1:0] <= len2_q;
      end
      if (hit(adr_i, IDX_PHASE3)) begin
        rdata_q[LEN_W-1:0] <= len3_q;
      end
      if (hit(adr_i, IDX_PHASE4)) begin
        rdata_q[LEN_W-1:0] <= len4_q;
      end
      if (hit(adr_i, IDX_DUTY)) begin
        rdata_q[DUTY_W-1:0] <= duty_q;
      end
      // Status: live phase and drive level, read only
      if (hit(adr_i, IDX_STATUS)) begin
        rdata_q[4:0] <= {drive_q, phase_q};
      end
    end
  end

  // Phase sequencer: a phase ends when its tick count reaches zero.
  // The prescaler restarts at each phase entry, so a phase of code N
  // lasts exactly N ticks plus one cycle for the hand-over.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= PH1;
      cnt_q <= LEN_RST;
      pre_q <= '0;
    end else if (cnt_q == '0) begin
      // Reload from the next phase's register on entry
      phase_q <= next_phase(phase_q);
      cnt_q <= phase_len(next_phase(phase_q));
      pre_q <= '0;
    end else if (pre_q == TICK_CYC - 1) begin
      // One 64 ms unit has elapsed
      pre_q <= '0;
      cnt_q <= cnt_q - 7'h1;
    end else begin
      pre_q <= pre_q + 32'h1;
    end
  end

  // Slot timer: 32 slots of 250 us make the 8 ms drive period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_pre_q <= '0;
      slot_q <= '0;
    end else if (slot_pre_q == PWM_SLOT_CYC - 1) begin
      slot_pre_q <= '0;
      slot_q <= slot_q + 5'h1; // Wraps after 32 slots
    end else begin
      slot_pre_q <= slot_pre_q + 32'h1;
    end
  end

  // High for slots 0..code, so code+1 of 32; all ones never goes low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= (slot_q <= duty_q);
    end
  end

  // Outputs straight from flip-flops
  assign dat_o = rdata_q;
  assign ack_o = ack_q;
  assign chan_a_sink_level_o = ctrl_q.sink_level;
  assign chan_a_ramp_on_o = ctrl_q.ramp_on;
  assign phase_o = phase_q;
  assign chan_a_drive_out_o = drive_q;

  // Reads never show bits 7 and up of any register
  property p_resv_zero;
    @(posedge clk_i) disable iff (rst_i)
      ack_o && !we_i |-> dat_o[31:8] == '0 && !dat_o[7];
  endproperty
  a_resv_zero: assert property (p_resv_zero)
    else $error("reserved read bits not zero");

  // A low-byte write to the level register loads the ramp enable from bit 5
  property p_ramp_write;
    @(posedge clk_i) disable iff (rst_i)
      wr_en && hit(adr_i, IDX_LEVEL_RAMP)
      |=> chan_a_ramp_on_o == $past(dat_i[RAMP_BIT]);
  endproperty
  a_ramp_write: assert property (p_ramp_write)
    else $error("ramp enable did not follow write");

  // Level code follows the write and holds through the ack
  property p_level_write;
    @(posedge clk_i) disable iff (rst_i)
      wr_en && hit(adr_i, IDX_LEVEL_RAMP)
      |=> chan_a_sink_level_o == $past(dat_i[3:0])
          ##1 $stable(chan_a_sink_level_o);
  endproperty
  a_level_write: assert property (p_level_write)
    else $error("sink level did not follow write");

  // Phase one begins with its full programmed count
  property p_ph1_load;
    @(posedge clk_i) disable iff (rst_i)
      $changed(phase_q) && phase_q == PH1 |-> cnt_q == $past(len1_q);
  endproperty
  a_ph1_load: assert property (p_ph1_load)
    else $error("phase one count not loaded");

  // Phase two begins with its full programmed count
  property p_ph2_load;
    @(posedge clk_i) disable iff (rst_i)
      $rose(phase_q[1]) |-> cnt_q == $past(len2_q);
  endproperty
  a_ph2_load: assert property (p_ph2_load)
    else $error("phase two count not loaded");

  // Phase three follows two and loads its own count
  property p_ph3_load;
    @(posedge clk_i) disable iff (rst_i)
      $rose(phase_q[2]) |-> $past(phase_q) == PH2
                            && cnt_q == $past(len3_q);
  endproperty
  a_ph3_load: assert property (p_ph3_load)
    else $error("phase three entry wrong");

  // Phase four loads its count; a nonzero count holds the phase
  property p_ph4_hold;
    @(posedge clk_i) disable iff (rst_i)
      $rose(phase_q[3]) && cnt_q != '0 |-> cnt_q == $past(len4_q)
                                         ##1 phase_q == PH4;
  endproperty
  a_ph4_hold: assert property (p_ph4_hold)
    else $error("phase four not held");

  // Reset leaves every writable register cleared
  property p_reset_clear;
    @(posedge clk_i)
      rst_i |=> ctrl_q == '0 && len1_q == '0 && len2_q == '0
                && len3_q == '0 && len4_q == '0 && duty_q == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("registers not cleared by reset");

  // Full duty code keeps the drive high
  property p_duty_full;
    @(posedge clk_i) disable iff (rst_i)
      duty_q == DUTY_FULL ##1 duty_q == DUTY_FULL |-> chan_a_drive_out_o;
  endproperty
  a_duty_full: assert property (p_duty_full)
    else $error("drive low with full duty code");

  // Drive level matches the slot compared with the duty code; the
  // edge that releases reset starts no attempt, as drive was cleared
  property p_duty_slot;
    @(posedge clk_i) disable iff (rst_i)
      !rst_i |=> chan_a_drive_out_o == ($past(slot_q) <= $past(duty_q));
  endproperty
  a_duty_slot: assert property (p_duty_slot)
    else $error("drive level disagrees with slot");

  // A phase only ends when its count is exhausted
  property p_phase_exit;
    @(posedge clk_i) disable iff (rst_i)
      cnt_q != '0 |=> $stable(phase_q);
  endproperty
  a_phase_exit: assert property (p_phase_exit)
    else $error("phase left with ticks remaining");

  // A low-byte write to phase one's length lands on the next edge
  property p_len1_write;
    @(posedge clk_i) disable iff (rst_i)
      wr_en && hit(adr_i, IDX_PHASE1)
      |=> len1_q == $past(dat_i[LEN_W-1:0]);
  endproperty
  a_len1_write: assert property (p_len1_write)
    else $error("phase one length did not follow write");

  // A phase entered with a zero count hands over on the next edge
  property p_zero_phase;
    @(posedge clk_i) disable iff (rst_i)
      $changed(phase_q) && cnt_q == '0
      |=> phase_q != $past(phase_q);
  endproperty
  a_zero_phase: assert property (p_zero_phase)
    else $error("zero-length phase held too long");

  // Reading phase four's register returns the stored length
  property p_len4_read;
    @(posedge clk_i) disable iff (rst_i)
      ack_o && !we_i && hit(adr_i, IDX_PHASE4)
      |-> dat_o[LEN_W-1:0] == $past(len4_q);
  endproperty
  a_len4_read: assert property (p_len4_read)
    else $error("phase four length read back wrong");

endmodule : led_a_pattern_timing_regs

// [testbench.sv]
module testbench
  import led_a_regs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // Short counts keep the pattern timing inside a quick run
  localparam int unsigned TK = 8;
  localparam int unsigned SL = 4;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [ADR_W-1:0] adr_i = '0;
  logic [SEL_W-1:0] sel_i = '0;
  logic [DAT_W-1:0] dat_i = '0;
  logic [DAT_W-1:0] dat_o;
  logic ack_o;
  logic [LEVEL_W-1:0] chan_a_sink_level_o;
  logic chan_a_ramp_on_o;
  logic [3:0] phase_o;
  logic chan_a_drive_out_o;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  // Every writable place plus one unmapped index
  logic [7:0] idx_tab [7] = '{IDX_LEVEL_RAMP, IDX_PHASE1, IDX_PHASE2,
    IDX_PHASE3, IDX_PHASE4, IDX_DUTY, 8'h50};

  led_a_pattern_timing_regs #(.TICK_CYC(TK), .PWM_SLOT_CYC(SL)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o),
    .chan_a_sink_level_o(chan_a_sink_level_o),
    .chan_a_ramp_on_o(chan_a_ramp_on_o), .phase_o(phase_o),
    .chan_a_drive_out_o(chan_a_drive_out_o));

  // Free-running 125 MHz clock
  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // Watchdog; the whole run needs well under this many cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      tally_and_finish();
    end
  end

  // Writable bits of each place; unmapped reads as zero
  function automatic logic [7:0] mask_of(input logic [7:0] idx);
    case (idx)
      IDX_LEVEL_RAMP: return 8'h2f;
      IDX_PHASE1, IDX_PHASE2, IDX_PHASE3, IDX_PHASE4: return 8'h7f;
      IDX_DUTY: return 8'h1f;
      default: return 8'h00;
    endcase
  endfunction : mask_of

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One classic cycle; held until ack is sampled high at an edge
  task automatic wb(input logic w, input logic [7:0] idx,
                    input logic [7:0] d, input logic s0,
                    output logic [31:0] r);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= {3'b000, s0};
    dat_i <= {24'($urandom), d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask : do_reset

  // All writable places read zero straight after reset
  task automatic check_zero();
    logic [31:0] r;
    foreach (idx_tab[i]) begin
      wb(1'b0, idx_tab[i], 8'h00, 1'b1, r);
      check(r, 32'h0);
    end
  endtask : check_zero

  // High cycles over one full drive period
  task automatic duty_run(input logic [4:0] code);
    logic [31:0] r;
    int hi;
    wb(1'b1, IDX_DUTY, {3'b111, code}, 1'b1, r);
    repeat (2 * 32 * SL) @(posedge clk_i);
    hi = 0;
    repeat (32 * SL) begin
      @(posedge clk_i);
      if (chan_a_drive_out_o === 1'b1) hi++;
    end
    check(hi, (code + 1) * SL);
  endtask : duty_run

  initial begin
    logic [31:0] r;
    logic [7:0] idx;
    logic [7:0] d;
    logic [6:0] len [4];
    int n;
    void'($urandom(37));
    do_reset();
    check_zero();
    check({chan_a_ramp_on_o, chan_a_sink_level_o}, 5'h00);
    // All ones: reserved bits dropped, fields kept
    foreach (idx_tab[i]) begin
      wb(1'b1, idx_tab[i], 8'hff, 1'b1, r);
      wb(1'b0, idx_tab[i], 8'h00, 1'b1, r);
      check(r, {24'h0, mask_of(idx_tab[i])});
    end
    // Lane zero disabled: the write is ignored
    wb(1'b1, IDX_LEVEL_RAMP, 8'h00, 1'b0, r);
    wb(1'b0, IDX_LEVEL_RAMP, 8'h00, 1'b1, r);
    check(r, 32'h2f);
    // Ramp and level each way round while phases are short
    foreach (idx_tab[i]) wb(1'b1, idx_tab[i], 8'h00, 1'b1, r);
    for (int k = 0; k < 6; k++) begin
      d = (k < 2) ? {2'b00, k[0], 1'b0, ~k[3:0]} : 8'($urandom);
      wb(1'b1, IDX_LEVEL_RAMP, d, 1'b1, r);
      repeat (4) @(posedge clk_i);
      check(chan_a_ramp_on_o, d[RAMP_BIT]);
      check(chan_a_sink_level_o, d[3:0]);
    end
    duty_run(5'h00);
    duty_run(5'h0b);
    duty_run(DUTY_FULL);
    // Random writes and readbacks across the map
    repeat (40) begin
      idx = idx_tab[$urandom_range(6, 0)];
      d = 8'($urandom);
      wb(1'b1, idx, d, 1'b1, r);
      wb(1'b0, idx, 8'h00, 1'b1, r);
      check(r, {24'h0, d & mask_of(idx)});
    end
    // Phase lengths: zero, small random, and the largest code
    len[0] = 7'h00;
    len[1] = 7'($urandom_range(15, 1));
    len[2] = 7'($urandom_range(15, 0));
    len[3] = 7'h7f;
    for (int k = 0; k < 4; k++) wb(1'b1, 8'(IDX_PHASE1 + k), {1'b1, len[k]},
                                   1'b1, r);
    do @(posedge clk_i); while (phase_o !== PH4);
    do @(posedge clk_i); while (phase_o !== PH1);
    for (int k = 0; k < 4; k++) begin
      n = 0;
      while (phase_o === 4'(1 << k)) begin
        n++;
        @(posedge clk_i);
      end
      check(n, len[k] * TK + 1);
    end
    // Status shows the live phase and drive; full duty holds drive high
    wb(1'b1, IDX_DUTY, {3'b000, DUTY_FULL}, 1'b1, r);
    do @(posedge clk_i); while (phase_o !== PH4);
    wb(1'b0, IDX_STATUS, 8'h00, 1'b1, r);
    check(r, {27'h0, 1'b1, PH4});
    // Second reset in mid-run clears every writable place again
    do_reset();
    check_zero();
    tally_and_finish();
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
endmodule : testbench
